//--- rtl/slc_link_ctrl.sv
// Link control for eight router link ports: start, refuse, drop, driver gating, status.
//
// Summary of operation
// R1 - Eight ports, each with control/status register
// R2 - Reset leaves every port in auto-start only
// R3 - Auto-start waits for remote attempt, then connects
// R4 - Link-start actively connects and reaches Run
// R5 - Data flows only when started and Run
// R6 - Disable drops running link, refuses remote attempts
// R7 - Software should keep its own port enabled
// R8 - Deactivate depends on auto, disable, start-on-request
// R9 - Auto plus deactivate: drivers on during connection
// R10 - Start-on-request plus deactivate: route request wakes port
// R11 - Disable plus deactivate: drivers always off
// R12 - Each port holds its own rate divider
// R13 - Data driver switches one cycle before strobe
// R14 - Seven-bit divider, rate is twice the clock over divider plus one
// R15 - Refuse dividers giving under two megabits
`timescale 1ns/10ps
`include "slc_defs.svh"

module slc_link_ctrl #(
   parameter int TX_CLK_MHZ = 100
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input slc_pkg::slc_bus_req_s bus,
   output logic [31:0] rdata,
   // Link codec side, one entry per port
   input slc_pkg::slc_link_in_s [7:0] link_in,
   input wire logic [7:0] route_req,
   output slc_pkg::slc_link_out_s [7:0] link_out,
   output logic [7:0][6:0] port_rate_divider,
   // Interrupt
   output logic irq
);
   import slc_pkg::*;

   // ------------------------------------------------------------
   // Constants
   // ------------------------------------------------------------
   localparam int RATE_LIM = (2 * TX_CLK_MHZ) / `SLC_MIN_RATE_MBPS - 1;
   localparam logic [6:0] RATE_MAX = (RATE_LIM > 127) ? `SLC_RATE_CEIL : 7'(RATE_LIM);
   localparam logic [11:0] RESET_CYC = 12'(`SLC_RESET_CYC);
   localparam logic [11:0] WAIT_CYC = 12'(`SLC_WAIT_CYC);
   localparam logic [11:0] TIMEOUT_CYC = 12'(`SLC_TIMEOUT_CYC);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic link_active(input slc_link_state_e s);
      return (s == ST_STARTED) || (s == ST_CONNECTING) || (s == ST_RUN);
   endfunction

   function automatic logic [31:0] port_word(input slc_port_s p);
      logic [31:0] w;
      w = '0;
      w[`SLC_CTL_AUTO] = p.ctrl.auto_start;
      w[`SLC_CTL_START] = p.ctrl.link_start;
      w[`SLC_CTL_DISABLE] = p.ctrl.link_disable;
      w[`SLC_CTL_DEACT] = p.ctrl.deactivate;
      w[`SLC_CTL_RATE_HI:`SLC_CTL_RATE_LO] = p.ctrl.port_rate_divider;
      w[`SLC_STS_ERR_DISC] = p.err_disc;
      w[`SLC_STS_ERR_RX] = p.err_rx;
      w[`SLC_STS_STATE_HI:`SLC_STS_STATE_LO] = p.st;
      w[`SLC_STS_RUN] = (p.st == ST_RUN);
      return w;
   endfunction

   slc_state_s state_reg;
   slc_state_s state_next;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      slc_port_s np;
      slc_ctrl_s wc;
      logic [7:0] ev_up;
      logic [7:0] ev_err;
      logic hit;
      logic restart;
      logic fault;
      logic kill;
      logic go;
      logic to_reset;
      logic want;
      logic [15:0] clr;
      np = '0;
      wc = '0;
      ev_up = '0;
      ev_err = '0;
      hit = 1'b0;
      restart = 1'b0;
      fault = 1'b0;
      kill = 1'b0;
      go = 1'b0;
      to_reset = 1'b0;
      want = 1'b0;
      clr = '0;
      state_next = state_reg;
      state_next.rdata = '0;
      if (bus.wr && bus.addr == `SLC_ADDR_ROUTER)
      begin
         state_next.sor = bus.wdata[`SLC_RTR_SOR];
      end
      if (bus.wr && bus.addr == `SLC_ADDR_IRQ_MASK)
      begin
         state_next.irq_mask = bus.wdata[`SLC_IRQ_W-1:0];
      end
      if (bus.wr && bus.addr == `SLC_ADDR_IRQ_STAT)
      begin
         clr = bus.wdata[`SLC_IRQ_W-1:0];
      end
      for (int i = 0; i < `SLC_NPORTS; i++)
      begin
         np = state_reg.port[i];
         hit = bus.wr && (bus.addr == `SLC_ADDR_PORT0 + 4'(i));
         restart = 1'b0;
         to_reset = 1'b0;
         // R1 - sticky error flags
         if (hit)
         begin
            if (bus.wdata[`SLC_STS_ERR_DISC])
            begin
               np.err_disc = 1'b0;
            end
            if (bus.wdata[`SLC_STS_ERR_RX])
            begin
               np.err_rx = 1'b0;
            end
            wc.auto_start = bus.wdata[`SLC_CTL_AUTO];
            wc.link_start = bus.wdata[`SLC_CTL_START];
            wc.link_disable = bus.wdata[`SLC_CTL_DISABLE];
            wc.deactivate = bus.wdata[`SLC_CTL_DEACT];
            // R12 - per-port divider
            wc.port_rate_divider = bus.wdata[`SLC_CTL_RATE_HI:`SLC_CTL_RATE_LO];
            // R15 - slow divider refused
            if (wc.port_rate_divider > RATE_MAX)
            begin
               wc.port_rate_divider = np.ctrl.port_rate_divider;
            end
            // R9 - control change ends wake
            restart = np.ctrl.deactivate && link_active(np.st)
               && (wc[10:7] != np.ctrl[10:7]);
            np.ctrl = wc;
         end
         if (np.timer != '0)
         begin
            np.timer = np.timer - 12'h001;
         end
         fault = link_in[i].rx_error || link_in[i].disconnect;
         // R6 - disable drops and refuses
         kill = np.ctrl.link_disable || restart;
         // R3 - remote attempt in auto-start
         // R4 - link-start connects
         // R10 - route request wakes port
         go = !np.ctrl.link_disable && (np.ctrl.link_start
            || (np.ctrl.auto_start && link_in[i].remote_null)
            || (state_reg.sor && route_req[i]));
         case (state_reg.port[i].st)
            ST_ERR_RESET:
            begin
               if (np.timer == '0)
               begin
                  np.st = ST_ERR_WAIT;
                  np.timer = WAIT_CYC;
               end
            end
            ST_ERR_WAIT:
            begin
               if (fault)
               begin
                  to_reset = 1'b1;
               end
               else if (np.timer == '0)
               begin
                  np.st = ST_READY;
               end
            end
            ST_READY:
            begin
               if (go)
               begin
                  np.st = ST_STARTED;
                  np.timer = TIMEOUT_CYC;
               end
            end
            ST_STARTED:
            begin
               if (fault || kill || np.timer == '0)
               begin
                  to_reset = 1'b1;
               end
               else if (link_in[i].remote_null)
               begin
                  np.st = ST_CONNECTING;
                  np.timer = TIMEOUT_CYC;
               end
            end
            ST_CONNECTING:
            begin
               if (fault || kill || np.timer == '0)
               begin
                  to_reset = 1'b1;
               end
               else if (link_in[i].remote_fct)
               begin
                  np.st = ST_RUN;
                  ev_up[i] = 1'b1;
               end
            end
            ST_RUN:
            begin
               if (fault || kill)
               begin
                  to_reset = 1'b1;
               end
            end
            default:
            begin
               to_reset = 1'b1;
            end
         endcase
         if (to_reset)
         begin
            np.st = ST_ERR_RESET;
            np.timer = RESET_CYC;
         end
         // Errors are only recorded while a connection exists, so idle noise is ignored.
         if (fault && link_active(state_reg.port[i].st))
         begin
            np.err_disc = np.err_disc | link_in[i].disconnect;
            np.err_rx = np.err_rx | link_in[i].rx_error;
            ev_err[i] = 1'b1;
         end
         // R8 - driver gating by control bits
         // R11 - disabled and deactivated stays off
         want = !np.ctrl.deactivate || (!np.ctrl.link_disable && link_active(np.st));
         np.out.link_enable = link_active(np.st);
         // R5 - transfer only in Run
         np.out.tx_allowed = (np.st == ST_RUN) && !np.ctrl.link_disable;
         np.out.data_drv_en = want;
         // R13 - strobe trails data
         np.out.link_strobe_output_en = state_reg.port[i].out.data_drv_en;
         state_next.port[i] = np;
      end
      // Set wins over clear so an event in the clearing cycle is kept.
      state_next.irq_stat = (state_reg.irq_stat & ~clr) | {ev_err, ev_up};
      state_next.irq = |(state_next.irq_stat & state_next.irq_mask);
      if (bus.rd)
      begin
         if (bus.addr < `SLC_ADDR_ROUTER)
         begin
            state_next.rdata = port_word(state_reg.port[bus.addr[2:0]]);
         end
         else if (bus.addr == `SLC_ADDR_ROUTER)
         begin
            state_next.rdata[`SLC_RTR_SOR] = state_reg.sor;
         end
         else if (bus.addr == `SLC_ADDR_IRQ_STAT)
         begin
            state_next.rdata[`SLC_IRQ_W-1:0] = state_reg.irq_stat;
         end
         else if (bus.addr == `SLC_ADDR_IRQ_MASK)
         begin
            state_next.rdata[`SLC_IRQ_W-1:0] = state_reg.irq_mask;
         end
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_reg <= '0;
         for (int i = 0; i < `SLC_NPORTS; i++)
         begin
            // R2 - auto-start after reset
            state_reg.port[i].ctrl.auto_start <= 1'b1;
            state_reg.port[i].ctrl.port_rate_divider <= `SLC_RATE_RST;
            state_reg.port[i].timer <= RESET_CYC;
         end
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign rdata = state_reg.rdata;
   assign irq = state_reg.irq;

   // R14 - seven-bit divider exported
   for (genvar gi = 0; gi < `SLC_NPORTS; gi++)
   begin : g_port
      assign link_out[gi] = state_reg.port[gi].out;
      assign port_rate_divider[gi] = state_reg.port[gi].ctrl.port_rate_divider;

      // ------------------------------------------------------------
      // Checks
      // ------------------------------------------------------------
      sequence s_data_drop;
         $fell(state_reg.port[gi].out.data_drv_en);
      endsequence

      sequence s_strobe_follow;
         state_reg.port[gi].out.link_strobe_output_en ##1
            !state_reg.port[gi].out.link_strobe_output_en;
      endsequence

      chk_reset_auto_only: assert property (@(posedge clk) // R2
         rst |=> state_reg.port[gi].ctrl.auto_start && !state_reg.port[gi].ctrl.link_start
            && !state_reg.port[gi].ctrl.link_disable && !state_reg.port[gi].ctrl.deactivate)
         else $error("port not in auto-start after reset");
      chk_strobe_after_data: assert property (@(posedge clk) disable iff (rst) // R13
         s_data_drop |-> s_strobe_follow)
         else $error("strobe driver did not trail data driver");
      chk_tx_only_run: assert property (@(posedge clk) disable iff (rst) // R5
         link_out[gi].tx_allowed |-> state_reg.port[gi].st == ST_RUN
            && $past(state_next.port[gi].st) == ST_RUN)
         else $error("data allowed outside Run");
      chk_disabled_dark: assert property (@(posedge clk) disable iff (rst) // R11
         (state_reg.port[gi].ctrl.link_disable && state_reg.port[gi].ctrl.deactivate)[*2]
            |-> !link_out[gi].data_drv_en && !link_out[gi].link_strobe_output_en)
         else $error("drivers on while disabled and deactivated");
      chk_disable_drops: assert property (@(posedge clk) disable iff (rst) // R6
         state_reg.port[gi].st == ST_RUN && bus.wr && bus.addr == `SLC_ADDR_PORT0 + 4'(gi)
            && bus.wdata[`SLC_CTL_DISABLE] |=> state_reg.port[gi].st == ST_ERR_RESET)
         else $error("running port not dropped on disable");
      chk_auto_waits: assert property (@(posedge clk) disable iff (rst) // R3
         state_reg.port[gi].st == ST_READY && !state_reg.port[gi].ctrl.link_start
            && !state_reg.sor && !link_in[gi].remote_null && !bus.wr
            |=> state_reg.port[gi].st == ST_READY)
         else $error("auto-start port left Ready without remote attempt");

      chk_start_connects: assert property (@(posedge clk) disable iff (rst) // R4
         state_reg.port[gi].st == ST_READY && state_reg.port[gi].ctrl.link_start
            && !state_reg.port[gi].ctrl.link_disable && !bus.wr
            |=> state_reg.port[gi].st == ST_STARTED)
         else $error("link-start did not start the port");

      chk_request_wakes: assert property (@(posedge clk) disable iff (rst) // R10
         state_reg.port[gi].st == ST_READY && state_reg.sor && route_req[gi]
            && state_reg.port[gi].ctrl.deactivate && !state_reg.port[gi].ctrl.link_disable
            && !bus.wr |=> link_out[gi].data_drv_en ##1 link_out[gi].link_strobe_output_en)
         else $error("route request did not wake the drivers");

      chk_auto_dark: assert property (@(posedge clk) disable iff (rst) // R9
         state_reg.port[gi].ctrl.deactivate && state_reg.port[gi].st == ST_READY
            |-> !link_out[gi].data_drv_en)
         else $error("drivers on before remote attempt");

      chk_rate_floor: assert property (@(posedge clk) disable iff (rst) // R15
         port_rate_divider[gi] <= RATE_MAX)
         else $error("rate divider below minimum rate");
   end

endmodule // slc_link_ctrl

//--- shared/slc_defs.svh
// Address map, field positions, reset values and timing counts of the link port control block.
`ifndef SLC_DEFS_SVH
`define SLC_DEFS_SVH

// ------------------------------------------------------------
// Register word addresses
// ------------------------------------------------------------
`define SLC_ADDR_PORT0 4'h0
`define SLC_ADDR_ROUTER 4'h8
`define SLC_ADDR_IRQ_STAT 4'h9
`define SLC_ADDR_IRQ_MASK 4'hA

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SLC_CTL_AUTO 0
`define SLC_CTL_START 1
`define SLC_CTL_DISABLE 2
`define SLC_CTL_DEACT 3
`define SLC_CTL_RATE_LO 8
`define SLC_CTL_RATE_HI 14
`define SLC_STS_ERR_DISC 16
`define SLC_STS_ERR_RX 17
`define SLC_STS_STATE_LO 24
`define SLC_STS_STATE_HI 26
`define SLC_STS_RUN 27
`define SLC_RTR_SOR 0
`define SLC_IRQ_W 16

// ------------------------------------------------------------
// Sizes and reset values
// ------------------------------------------------------------
`define SLC_NPORTS 8
`define SLC_RATE_W 7
`define SLC_TMR_W 12
`define SLC_RATE_RST 7'h00
`define SLC_RATE_CEIL 7'h7F
`define SLC_MIN_RATE_MBPS 2

// ------------------------------------------------------------
// Timing: times in ns, counts derived at a 4 ns clock
// ------------------------------------------------------------
`define SLC_CLK_NS 4
`define SLC_T_RESET_NS 6400
`define SLC_T_WAIT_NS 12800
`define SLC_T_TIMEOUT_NS 12800
`define SLC_RESET_CYC ((`SLC_T_RESET_NS + `SLC_CLK_NS - 1) / `SLC_CLK_NS)
`define SLC_WAIT_CYC ((`SLC_T_WAIT_NS + `SLC_CLK_NS - 1) / `SLC_CLK_NS)
`define SLC_TIMEOUT_CYC (`SLC_T_TIMEOUT_NS / `SLC_CLK_NS)

`endif

//--- shared/slc_pkg.sv
// Types shared by the link port control block and its users.
package slc_pkg;

   // ------------------------------------------------------------
   // Link state machine
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_ERR_RESET,
      ST_ERR_WAIT,
      ST_READY,
      ST_STARTED,
      ST_CONNECTING,
      ST_RUN
   } slc_link_state_e;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } slc_bus_req_s;

   typedef struct packed {
      logic auto_start;
      logic link_start;
      logic link_disable;
      logic deactivate;
      logic [6:0] port_rate_divider;
   } slc_ctrl_s;

   typedef struct packed {
      logic remote_null;
      logic remote_fct;
      logic rx_error;
      logic disconnect;
   } slc_link_in_s;

   typedef struct packed {
      logic link_enable;
      logic tx_allowed;
      logic data_drv_en;
      logic link_strobe_output_en;
   } slc_link_out_s;

   typedef struct packed {
      slc_ctrl_s ctrl;
      slc_link_state_e st;
      logic [11:0] timer;
      logic err_disc;
      logic err_rx;
      slc_link_out_s out;
   } slc_port_s;

   typedef struct packed {
      slc_port_s [7:0] port;
      logic sor;
      logic [15:0] irq_stat;
      logic [15:0] irq_mask;
      logic irq;
      logic [31:0] rdata;
   } slc_state_s;

endpackage

//--- verif/slc_remote_node.sv
// Behavioural far-end link partner for each of the eight router ports.
`timescale 1ns/10ps

module slc_remote_node (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Router side of each link
   input slc_pkg::slc_link_out_s [7:0] link_out,
   output slc_pkg::slc_link_in_s [7:0] link_in,
   // Scenario controls
   input wire logic [7:0] attempt,
   input wire logic [7:0] drop,
   input wire logic slow
);
   import slc_pkg::*;

   int cnt [8];
   int lag;

   // ------------------------------------------------------------
   // Handshake timing
   // ------------------------------------------------------------
   // The far end only talks while it wants a link or sees ours enabled, so a
   // dropped link drops FCT at once and nulls one clock later instead of lingering on stale levels.
   always_comb
      lag = slow ? 60 : 3;

   always_ff @(posedge clk)
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (rst || !(attempt[i] || link_out[i].link_enable))
            cnt[i] <= 0;
         else if (cnt[i] < 1000)
            cnt[i] <= cnt[i] + 1;
      end
   end

   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         link_in[i].remote_null = (cnt[i] >= lag);
         link_in[i].remote_fct = link_out[i].link_enable && (cnt[i] >= 2 * lag);
         link_in[i].rx_error = 1'b0;
         link_in[i].disconnect = drop[i];
      end
   end
endmodule // slc_remote_node

//--- verif/testbench.sv
// Self-checking bench for the link port control block.
`timescale 1ns/10ps

module testbench;
   import slc_pkg::*;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam int TXMHZ = 40;
   logic clk = 1'b0;
   logic rst = 1'b1;
   slc_bus_req_s bus = '0;
   logic [31:0] rdata;
   slc_link_in_s [7:0] link_in;
   slc_link_out_s [7:0] link_out;
   logic [7:0] route_req = 8'h00;
   logic [7:0][6:0] port_rate_divider;
   logic irq;
   logic [7:0] attempt = 8'h00;
   logic [7:0] drop = 8'h00;
   logic slow = 1'b0;
   logic [7:0] dvec;
   logic [7:0] svec;
   logic [7:0] dvec_d = 8'h00;
   logic rst_d = 1'b1;
   logic [31:0] rd_val;
   logic [6:0] d7;
   logic [6:0] bnd [4] = '{7'h27, 7'h28, 7'h7F, 7'h00};
   int err_total = 0;
   int checks = 0;
   int seed = 32'hC2C3;
   int mdl [8];
   int n;

   // ------------------------------------------------------------
   // Design and far end
   // ------------------------------------------------------------
   slc_link_ctrl #(.TX_CLK_MHZ(TXMHZ)) dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
      .link_in(link_in), .route_req(route_req), .link_out(link_out),
      .port_rate_divider(port_rate_divider), .irq(irq));

   slc_remote_node far_end (.clk(clk), .rst(rst), .link_out(link_out), .link_in(link_in),
      .attempt(attempt), .drop(drop), .slow(slow));

   initial
   begin
      forever #2 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
      if (a < 4'h8)
         mdl[a] = int'(d[14:8] <= TXMHZ - 1 ? d & 32'h7F0F : mdl[a] & 32'h7F00 | d & 32'hF);
   endtask

   task automatic bus_rd(input logic [3:0] a);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      rd_val = rdata;
   endtask

   // Error flags are left out: which flag a drop sets is not pinned down.
   task automatic chk_port(input int i, input int st);
      bus_rd(4'(i));
      check(rd_val & 32'hFFFC_FFFF, 32'(mdl[i]) | 32'(st) << 24 | 32'(st == 5) << 27);
   endtask

   task automatic drv_chk(input int i, input logic [1:0] e);
      #1;
      check(32'({dvec[i], svec[i]}), 32'(e));
   endtask

   task automatic wait_run(input int i);
      int pre;
      pre = 0;
      n = 0;
      while (link_out[i].tx_allowed !== 1'b1 && n < 8000)
      begin
         @(posedge clk);
         #1;
         n++;
         pre += int'(link_out[i].link_enable === 1'b1);
      end
      check(32'(n < 8000), 32'h1);
      // Started and Connecting come before Run
      check(32'(pre >= 3), 32'h1);
   endtask

   task automatic tdone(input string s);
      $display("test %s finished", s);
   endtask

   // ------------------------------------------------------------
   // Driver pair monitor
   // ------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         dvec[i] = link_out[i].data_drv_en;
         svec[i] = link_out[i].link_strobe_output_en;
      end
   end

   always @(posedge clk)
   begin
      if (!rst && !rst_d)
         check({24'h0, svec}, {24'h0, dvec_d});
      dvec_d <= dvec;
      rst_d <= rst;
   end

   initial
   begin
      repeat (40000) @(posedge clk);
      err_total++;
      complete_run();
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial
   begin
      for (int i = 0; i < 8; i++)
         mdl[i] = 1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++)
         chk_port(i, 0);
      for (int a = 8; a < 12; a++)
      begin
         bus_rd(4'(a));
         check(rd_val, 32'h0);
      end
      check(32'({link_out[0].link_enable, link_out[0].tx_allowed, irq}), 32'h0);
      tdone("reset");
      repeat (4850) @(posedge clk);
      chk_port(3, 2);
      check(32'(link_out[3].link_enable), 32'h0);
      tdone("idle");
      bus_wr(4'h1, 32'h3);
      wait_run(1);
      chk_port(1, 5);
      bus_rd(4'h9);
      check(rd_val, 32'h2);
      check(32'(irq), 32'h0);
      bus_wr(4'hA, 32'h2);
      repeat (2) @(posedge clk);
      #1;
      check(32'(irq), 32'h1);
      bus_wr(4'h9, 32'h2);
      repeat (2) @(posedge clk);
      #1;
      check(32'(irq), 32'h0);
      tdone("start");
      // port 0 stays enabled, it is the configuring link
      bus_wr(4'h1, 32'h4);
      repeat (2) @(posedge clk);
      chk_port(1, 0);
      check(32'(link_out[1].tx_allowed), 32'h0);
      bus_rd(4'h9);
      // A commanded disable is not a link error, so no error event is raised.
      check(rd_val, 32'h0);
      check(32'(irq), 32'h0);
      bus_wr(4'h9, 32'h200);
      tdone("disable");
      @(posedge clk);
      slow <= 1'b1;
      attempt[2] <= 1'b1;
      wait_run(2);
      chk_port(2, 5);
      @(posedge clk);
      slow <= 1'b0;
      tdone("auto");
      bus_wr(4'h4, 32'h9);
      repeat (3) @(posedge clk);
      drv_chk(4, 2'b00);
      @(posedge clk);
      attempt[4] <= 1'b1;
      wait_run(4);
      drv_chk(4, 2'b11);
      @(posedge clk);
      attempt[4] <= 1'b0;
      drop[4] <= 1'b1;
      @(posedge clk);
      drop[4] <= 1'b0;
      repeat (4) @(posedge clk);
      drv_chk(4, 2'b00);
      chk_port(4, 0);
      // Ports 2 and 4 reached Run, then port 4 saw a disconnect while running.
      bus_rd(4'h9);
      check(rd_val, 32'h1014);
      tdone("auto deactivate");
      bus_wr(4'h8, 32'h1);
      bus_wr(4'h5, 32'h8);
      repeat (3) @(posedge clk);
      drv_chk(5, 2'b00);
      @(posedge clk);
      route_req[5] <= 1'b1;
      wait_run(5);
      drv_chk(5, 2'b11);
      @(posedge clk);
      route_req[5] <= 1'b0;
      tdone("request");
      for (int k = 0; k < 10; k++)
      begin
         d7 = (k < 4) ? bnd[k] : 7'($random(seed));
         bus_wr(4'h6, {17'h0, d7, 8'h01});
         chk_port(6, 2);
         check(32'(port_rate_divider[6]), 32'(mdl[6] >> 8));
      end
      check(32'(port_rate_divider[7]), 32'h0);
      tdone("divider");
      rd_val = '0;
      n = 0;
      while (rd_val[26:24] !== 3'h2 && n < 4000)
      begin
         bus_rd(4'h1);
         n++;
      end
      @(posedge clk);
      attempt[1] <= 1'b1;
      repeat (80) @(posedge clk);
      chk_port(1, 2);
      check(32'(link_out[1].link_enable), 32'h0);
      bus_wr(4'h1, 32'hC);
      repeat (40) @(posedge clk);
      drv_chk(1, 2'b00);
      tdone("refuse");
      complete_run();
   end
endmodule // testbench
